/* File: core/apf_pkg.sv */
// apf_pkg: constants, types and helpers of the audio port block
// Overview of operation
// - slot size 8 to 32 bits, steps of four
// - reverse control bit-reverses received slot word
// - rotate received word right by 0 to 28
// - final mask keeps bits, pads others by choice
// - count sysclks per 32 master clocks, range-check
// - selected errors or mute input drive mute pin
// - selected error sources raise interrupt
// - burst: sync too early is unexpected
// - tdm: sync only at exact bit, before slot0
// - early sync: flag, finish frame, resync later
// - frame gap: flag at once, resync next sync
// - per slot, unrewritten buffer transfer is underrun
// - underrun flag sticky, write one clears
// - biphase mode underrun sends BIPHASE_ZEROS pattern
// - tdm underrun, not biphase, shifts zeros until port reset
// - per slot, unread buffer overwritten, overrun flagged
// - overrun flag sticky, write one clears
// - extra words per dma event flag dma error
package apf_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RXFMT = 8'h04;
    localparam logic [7:0] ADDR_RXMASK = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_MUTE = 8'h10;
    localparam logic [7:0] ADDR_INTEN = 8'h14;
    localparam logic [7:0] ADDR_RXDATA = 8'h18;
    localparam logic [7:0] ADDR_TXDATA = 8'h1C;
    localparam logic [7:0] ADDR_CLKCHK_TX = 8'h20;
    localparam logic [7:0] ADDR_CLKCHK_RX = 8'h24;

    // control register fields
    localparam int CTRL_SOFT_RST = 8;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // status flag positions
    localparam int NFLAG = 7;
    localparam int F_RX_OVR = 0;
    localparam int F_RX_SYNC = 1;
    localparam int F_RX_CLK = 2;
    localparam int F_TX_UND = 3;
    localparam int F_TX_SYNC = 4;
    localparam int F_TX_DMA = 5;
    localparam int F_TX_CLK = 6;

    // clock check register fields
    localparam int CK_MIN_LSB = 0;
    localparam int CK_MAX_LSB = 8;
    localparam logic [7:0] CK_MIN_RST = 8'h00;
    localparam logic [7:0] CK_MAX_RST = 8'hFF;
    localparam logic [7:0] SYS_CNT_SAT = 8'hFF;
    localparam logic [4:0] HCLK_LAST = 5'h1F;

    // synchronised pin positions
    localparam int NPIN = 6;
    localparam int PIN_BCLK = 0;
    localparam int PIN_FS = 1;
    localparam int PIN_RXD = 2;
    localparam int PIN_HCLK_TX = 3;
    localparam int PIN_HCLK_RX = 4;
    localparam int PIN_MUTE_IN = 5;

    // slot sizes and patterns
    localparam int SLOT_MIN_BITS = 8;
    localparam int SLOT_STEP = 4;
    localparam logic [2:0] SLOT_CODE_MAX = 3'h6;
    localparam logic [1:0] DELAY_MAX = 2'h2;
    localparam logic [31:0] RXMASK_RST = 32'hFFFF_FFFF;
    localparam logic [31:0] BIPHASE_ZEROS = 32'hCCCC_CCCC;

    localparam logic [1:0] PAD_ZERO = 2'h0;
    localparam logic [1:0] PAD_ONE = 2'h1;
    localparam logic [1:0] PAD_BIT = 2'h2;

    typedef struct packed {
        logic [4:0] pad_bit;
        logic [1:0] pad_mode;
        logic [1:0] data_delay;
        logic [2:0] slot_size;
        logic reverse;
        logic [2:0] rotate;
    } apf_rxfmt_t;

    localparam apf_rxfmt_t RXFMT_RST = '0;

    typedef enum logic [1:0] {
        S_IDLE,
        S_DELAY,
        S_ACTIVE,
        S_NEXT
    } apf_frame_state_t;

    function automatic logic [5:0] slot_bits(input logic [2:0] code);
        if (code > SLOT_CODE_MAX) begin
            slot_bits = 6'(SLOT_MIN_BITS + SLOT_STEP * int'(SLOT_CODE_MAX));
        end else begin
            slot_bits = 6'(SLOT_MIN_BITS + SLOT_STEP * int'(code));
        end
    endfunction : slot_bits

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : byte_mask

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wdat, input logic [3:0] sel);
        wmerge = (old & ~byte_mask(sel)) | (wdat & byte_mask(sel));
    endfunction : wmerge

endpackage : apf_pkg

/* File: core/apf_rxfmt.sv */
// apf_rxfmt: receive format unit: reverse, rotate, mask and pad
`timescale 1ns/1ps
`default_nettype none
module apf_rxfmt (
    // configuration
    input wire apf_pkg::apf_rxfmt_t cfg_i,
    input wire logic [31:0] mask_i,
    // data
    input wire logic [31:0] slot_word_i,
    output logic [31:0] word_o
);
    import apf_pkg::*;

    logic [31:0] rev;
    logic [63:0] dbl;
    logic [31:0] rot;
    logic pad;

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            rev[i] = cfg_i.reverse ? slot_word_i[31 - i] : slot_word_i[i];
        end
        dbl = {rev, rev} >> {cfg_i.rotate, 2'b00};
        rot = dbl[31:0];
        case (cfg_i.pad_mode)
            PAD_ONE: pad = 1'b1;
            PAD_BIT: pad = rot[cfg_i.pad_bit];
            default: pad = 1'b0;
        endcase
        for (int i = 0; i < 32; i++) begin
            word_o[i] = mask_i[i] ? rot[i] : pad;
        end
    end

endmodule : apf_rxfmt
`default_nettype wire

/* File: core/apf_top.sv */
// apf_top: audio port framer, receive formatting, error flags, clock check and mute
`timescale 1ns/1ps
`default_nettype none
module apf_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial link
    input wire logic bclk_i,
    input wire logic fsync_i,
    input wire logic rx_data_i,
    output logic tx_data_o,
    input wire logic tx_high_rate_clock_i,
    input wire logic rx_high_rate_clock_i,
    // mute and events
    input wire logic mute_input_pin_i,
    output logic mute_output_pin_o,
    output logic tx_dma_req_o,
    output logic rx_dma_req_o,
    output logic err_irq_o
);
    import apf_pkg::*;

    // pin synchronisers
    logic [NPIN-1:0] pin_meta_reg;
    logic [NPIN-1:0] pin_sync_reg;
    logic bclk_prev_reg;
    logic fs_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {mute_input_pin_i, rx_high_rate_clock_i, tx_high_rate_clock_i,
                             rx_data_i, fsync_i, bclk_i};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    logic tick;
    logic fs_edge;
    assign tick = pin_sync_reg[PIN_BCLK] & ~bclk_prev_reg;
    assign fs_edge = tick & pin_sync_reg[PIN_FS] & ~fs_prev_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bclk_prev_reg <= 1'b0;
            fs_prev_reg <= 1'b0;
        end else begin
            bclk_prev_reg <= pin_sync_reg[PIN_BCLK];
            if (tick) begin
                fs_prev_reg <= pin_sync_reg[PIN_FS];
            end
        end
    end

    // software registers
    logic enable_reg;
    logic tdm_reg;
    logic biphase_audio_tx_mode_reg;
    logic [4:0] slots_m1_reg;
    apf_rxfmt_t receive_format_register_reg;
    logic [31:0] rx_mask_reg;
    logic [NFLAG-1:0] mute_sel_reg;
    logic mute_in_en_reg;
    logic mute_level_reg;
    logic [NFLAG-1:0] int_en_reg;
    logic [7:0] clk_min_reg [2];
    logic [7:0] clk_max_reg [2];
    logic [7:0] clk_cnt_reg [2];
    logic [NFLAG-1:0] flags_reg;
    logic [31:0] rx_buf_reg;
    logic rx_full_reg;
    logic [31:0] serializer_buffer_reg;
    logic tx_fresh_reg;
    logic zero_lock_reg;

    logic wb_req;
    logic wr_fire;
    logic rd_fire;
    logic soft_rst;
    logic port_rst;
    logic [31:0] wr_word;
    logic [31:0] rd_word;

    assign wb_req = wb_cyc_i & wb_stb_i;
    assign wr_fire = wb_req & wb_we_i & wb_ack_o;
    assign rd_fire = wb_req & ~wb_we_i & wb_ack_o;
    assign soft_rst = wr_fire && wb_adr_i == ADDR_CTRL && wb_sel_i[1] && wb_dat_i[CTRL_SOFT_RST];
    assign port_rst = rst_i | soft_rst;
    assign wr_word = wmerge(32'({clk_max_reg[wb_adr_i[2]], clk_min_reg[wb_adr_i[2]]}), wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_word;
            end
        end
    end

    always_comb begin
        case (wb_adr_i)
            ADDR_CTRL: rd_word = 32'({slots_m1_reg, biphase_audio_tx_mode_reg, tdm_reg, enable_reg});
            ADDR_RXFMT: rd_word = 32'(receive_format_register_reg);
            ADDR_RXMASK: rd_word = rx_mask_reg;
            ADDR_STATUS: rd_word = 32'({zero_lock_reg, tx_fresh_reg, rx_full_reg, flags_reg});
            ADDR_MUTE: rd_word = 32'({mute_level_reg, mute_in_en_reg, mute_sel_reg});
            ADDR_INTEN: rd_word = 32'(int_en_reg);
            ADDR_RXDATA: rd_word = rx_buf_reg;
            ADDR_CLKCHK_TX: rd_word = 32'({clk_cnt_reg[0], clk_max_reg[0], clk_min_reg[0]});
            ADDR_CLKCHK_RX: rd_word = 32'({clk_cnt_reg[1], clk_max_reg[1], clk_min_reg[1]});
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // configuration writes honour byte enables
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            {slots_m1_reg, biphase_audio_tx_mode_reg, tdm_reg, enable_reg} <= CTRL_RST;
            receive_format_register_reg <= RXFMT_RST;
            rx_mask_reg <= RXMASK_RST;
            {mute_level_reg, mute_in_en_reg, mute_sel_reg} <= '0;
            int_en_reg <= '0;
            for (int k = 0; k < 2; k++) begin
                clk_min_reg[k] <= CK_MIN_RST;
                clk_max_reg[k] <= CK_MAX_RST;
            end
        end else if (wr_fire) begin
            case (wb_adr_i)
                ADDR_CTRL: {slots_m1_reg, biphase_audio_tx_mode_reg, tdm_reg, enable_reg} <=
                    8'(wmerge(32'({slots_m1_reg, biphase_audio_tx_mode_reg, tdm_reg, enable_reg}),
                              wb_dat_i, wb_sel_i));
                ADDR_RXFMT: receive_format_register_reg <=
                    apf_rxfmt_t'(16'(wmerge(32'(receive_format_register_reg), wb_dat_i, wb_sel_i)));
                ADDR_RXMASK: rx_mask_reg <= wmerge(rx_mask_reg, wb_dat_i, wb_sel_i);
                ADDR_MUTE: {mute_level_reg, mute_in_en_reg, mute_sel_reg} <=
                    9'(wmerge(32'({mute_level_reg, mute_in_en_reg, mute_sel_reg}), wb_dat_i, wb_sel_i));
                ADDR_INTEN: int_en_reg <= NFLAG'(wmerge(32'(int_en_reg), wb_dat_i, wb_sel_i));
                ADDR_CLKCHK_TX, ADDR_CLKCHK_RX: begin
                    clk_min_reg[wb_adr_i[2]] <= wr_word[CK_MIN_LSB +: 8];
                    clk_max_reg[wb_adr_i[2]] <= wr_word[CK_MAX_LSB +: 8];
                end
                default: ;
            endcase
        end
    end

    // frame tracking
    apf_frame_state_t state_reg;
    logic [1:0] dly_cnt_reg;
    logic armed_reg;
    logic [10:0] fbit_reg;
    logic [5:0] bidx_reg;
    logic [5:0] sbits;
    logic [10:0] frame_bits;
    logic [1:0] dly;
    logic [10:0] fbit_cur;
    logic [5:0] bidx_cur;
    logic [10:0] rem;
    logic start_now;
    logic first_bit;
    logic data_bit;
    logic sync_err;
    logic arm_set;
    logic slot_first;
    logic slot_last;
    logic frame_last;

    always_comb begin
        sbits = slot_bits(receive_format_register_reg.slot_size);
        frame_bits = tdm_reg ? 11'((int'(slots_m1_reg) + 1) * int'(sbits)) : 11'(sbits);
        dly = (receive_format_register_reg.data_delay > DELAY_MAX) ? DELAY_MAX
                                                                   : receive_format_register_reg.data_delay;
        start_now = 1'b0;
        first_bit = 1'b0;
        sync_err = 1'b0;
        arm_set = 1'b0;
        case (state_reg)
            S_IDLE: begin
                start_now = fs_edge;
            end
            S_DELAY: begin
                sync_err = fs_edge;
                first_bit = tick && dly_cnt_reg == 2'h1;
            end
            S_ACTIVE: begin
                // expected sync: dly bits before frame end
                if (fs_edge && rem == 11'(dly)) begin
                    arm_set = 1'b1;
                end else if (fs_edge) begin
                    sync_err = 1'b1;
                end
            end
            S_NEXT: begin
                if (armed_reg) begin
                    first_bit = tick;
                    sync_err = fs_edge;
                end else if (fs_edge) begin
                    start_now = 1'b1;
                    sync_err = dly != 2'h0;
                end else begin
                    sync_err = tick;
                end
            end
            default: ;
        endcase
        if (start_now && dly == 2'h0) begin
            first_bit = 1'b1;
        end
        data_bit = tick & (state_reg == S_ACTIVE | first_bit);
        fbit_cur = first_bit ? 11'h000 : fbit_reg;
        bidx_cur = (first_bit || bidx_reg == sbits) ? 6'h00 : bidx_reg;
        rem = frame_bits - fbit_cur;
        slot_first = bidx_cur == 6'h00;
        slot_last = bidx_cur == sbits - 6'h01;
        frame_last = fbit_cur == frame_bits - 11'h001;
    end

    always_ff @(posedge clk_i) begin
        if (port_rst || !enable_reg) begin
            state_reg <= S_IDLE;
            dly_cnt_reg <= 2'h0;
            armed_reg <= 1'b0;
            fbit_reg <= 11'h000;
            bidx_reg <= 6'h00;
        end else if (tick) begin
            if (arm_set) begin
                armed_reg <= 1'b1;
            end else if (first_bit) begin
                armed_reg <= 1'b0;
            end
            if (data_bit) begin
                fbit_reg <= fbit_cur + 11'h001;
                bidx_reg <= bidx_cur + 6'h01;
                state_reg <= frame_last ? S_NEXT : S_ACTIVE;
            end else begin
                case (state_reg)
                    S_IDLE, S_NEXT: begin
                        state_reg <= start_now ? S_DELAY : S_IDLE;
                        dly_cnt_reg <= dly;
                    end
                    S_DELAY: dly_cnt_reg <= dly_cnt_reg - 2'h1;
                    default: state_reg <= S_IDLE;
                endcase
            end
        end
    end

    // receive serializer and buffer
    logic [31:0] serializer_shift_register_reg;
    logic [31:0] rx_slot_word;
    logic [31:0] rx_fmt_word;
    logic rx_slot_done;
    logic rx_ovr_evt;

    assign rx_slot_word = {pin_sync_reg[PIN_RXD], slot_first ? 31'h0 : serializer_shift_register_reg[31:1]};
    assign rx_slot_done = data_bit & slot_last;
    logic rd_fire_rx;
    assign rd_fire_rx = rd_fire && wb_adr_i == ADDR_RXDATA;
    assign rx_ovr_evt = rx_slot_done & rx_full_reg & ~rd_fire_rx;

    apf_rxfmt u_rxfmt (
        .cfg_i(receive_format_register_reg),
        .mask_i(rx_mask_reg),
        .slot_word_i(rx_slot_word),
        .word_o(rx_fmt_word)
    );

    always_ff @(posedge clk_i) begin
        if (port_rst) begin
            serializer_shift_register_reg <= 32'h0000_0000;
            rx_buf_reg <= 32'h0000_0000;
            rx_full_reg <= 1'b0;
            rx_dma_req_o <= 1'b0;
        end else begin
            rx_dma_req_o <= rx_slot_done;
            if (data_bit) begin
                serializer_shift_register_reg <= rx_slot_word;
            end
            if (rx_slot_done) begin
                rx_buf_reg <= rx_fmt_word;
                rx_full_reg <= 1'b1;
            end else if (rd_fire_rx) begin
                rx_full_reg <= 1'b0;
            end
        end
    end

    // transmit serializer
    logic [31:0] tx_sh_reg;
    logic [31:0] tx_load;
    logic tx_xfer;
    logic tx_und_evt;
    logic tx_wr;
    logic tx_dma_evt;

    assign tx_xfer = data_bit & slot_first;
    assign tx_und_evt = tx_xfer & ~tx_fresh_reg;
    assign tx_wr = wr_fire && wb_adr_i == ADDR_TXDATA;
    assign tx_dma_evt = tx_wr & tx_fresh_reg & ~tx_xfer;

    always_comb begin
        if (!tx_xfer) begin
            tx_load = tx_sh_reg;
        end else if (tx_fresh_reg) begin
            tx_load = serializer_buffer_reg;
        end else if (biphase_audio_tx_mode_reg) begin
            tx_load = BIPHASE_ZEROS;
        end else begin
            tx_load = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (port_rst) begin
            tx_sh_reg <= 32'h0000_0000;
            tx_data_o <= 1'b0;
            serializer_buffer_reg <= 32'h0000_0000;
            tx_fresh_reg <= 1'b0;
            zero_lock_reg <= 1'b0;
            tx_dma_req_o <= 1'b0;
        end else begin
            tx_dma_req_o <= tx_xfer;
            if (data_bit) begin
                tx_data_o <= zero_lock_reg ? 1'b0 : tx_load[31];
                tx_sh_reg <= {tx_load[30:0], 1'b0};
            end
            if (tx_und_evt && tdm_reg && !biphase_audio_tx_mode_reg) begin
                zero_lock_reg <= 1'b1;
            end
            if (tx_wr && !tx_dma_evt) begin
                serializer_buffer_reg <= wmerge(serializer_buffer_reg, wb_dat_i, wb_sel_i);
                tx_fresh_reg <= 1'b1;
            end else if (tx_xfer) begin
                tx_fresh_reg <= 1'b0;
            end
        end
    end

    // master clock range check
    logic [1:0] clk_fail;

    for (genvar k = 0; k < 2; k++) begin : g_clkchk
        logic hprev_reg;
        logic [4:0] hcnt_reg;
        logic [7:0] sys_reg;
        logic hedge;
        logic mark;
        assign hedge = pin_sync_reg[PIN_HCLK_TX + k] & ~hprev_reg;
        assign mark = hedge && hcnt_reg == HCLK_LAST;
        assign clk_fail[k] = (mark && sys_reg < clk_min_reg[k]) || sys_reg > clk_max_reg[k];
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                hprev_reg <= 1'b0;
                hcnt_reg <= 5'h00;
                sys_reg <= 8'h00;
                clk_cnt_reg[k] <= 8'h00;
            end else begin
                hprev_reg <= pin_sync_reg[PIN_HCLK_TX + k];
                if (hedge) begin
                    hcnt_reg <= hcnt_reg + 5'h01;
                end
                if (mark) begin
                    clk_cnt_reg[k] <= sys_reg;
                    sys_reg <= 8'h00;
                end else if (sys_reg != SYS_CNT_SAT) begin
                    sys_reg <= sys_reg + 8'h01;
                end
            end
        end
    end

    // sticky flags, write one clears, set wins
    logic [NFLAG-1:0] flag_set;
    logic [NFLAG-1:0] flag_clr;

    always_comb begin
        flag_set = '0;
        flag_set[F_RX_OVR] = rx_ovr_evt;
        flag_set[F_RX_SYNC] = sync_err;
        flag_set[F_TX_SYNC] = sync_err;
        flag_set[F_TX_UND] = tx_und_evt;
        flag_set[F_TX_DMA] = tx_dma_evt;
        flag_set[F_TX_CLK] = clk_fail[0];
        flag_set[F_RX_CLK] = clk_fail[1];
        flag_clr = (wr_fire && wb_adr_i == ADDR_STATUS) ? NFLAG'(wb_dat_i & byte_mask(wb_sel_i)) : '0;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end

    // mute pin and error interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mute_output_pin_o <= 1'b1;
            err_irq_o <= 1'b0;
        end else begin
            if ((|(flags_reg & mute_sel_reg)) || (mute_in_en_reg && pin_sync_reg[PIN_MUTE_IN])) begin
                mute_output_pin_o <= mute_level_reg;
            end else begin
                mute_output_pin_o <= ~mute_level_reg;
            end
            err_irq_o <= |(flags_reg & int_en_reg);
        end
    end

endmodule : apf_top
`default_nettype wire

/* File: core/placeholder_removed.sv */
// empty compile unit
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: testbench/apf_top_assertions.sv */
// apf_top_assertions: port checks of the audio port block
`timescale 1ns/1ps
`default_nettype none
module apf_top_assertions (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic tx_dma_req_o,
    input wire logic rx_dma_req_o,
    input wire logic mute_output_pin_o,
    input wire logic err_irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_ack_idle_bus: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without request");
    a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without strobe");
    a_rx_word_gap: assert property (rx_dma_req_o |=> !rx_dma_req_o [*8])
        else $error("rx words too close");
    a_tx_slot_gap: assert property (tx_dma_req_o |=> !tx_dma_req_o [*8])
        else $error("tx slots too close");
    a_mute_after_reset: assert property ($past(rst_i) |-> mute_output_pin_o)
        else $error("mute pin not idle");
    a_irq_after_reset: assert property ($past(rst_i) |-> !err_irq_o)
        else $error("irq after reset");
endmodule : apf_top_assertions
bind apf_top apf_top_assertions i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .tx_dma_req_o, .rx_dma_req_o, .mute_output_pin_o, .err_irq_o);
`default_nettype wire

/* File: testbench/apf_codec.sv */
// apf_codec: converter model: bit clock, sync and data
`timescale 1ns/1ps
`default_nettype none
module apf_codec (
    // serial link
    output logic bclk_o,
    output logic fsync_o,
    output logic rxd_o,
    input wire logic txd_i
);
    logic [31:0] txcap = 32'h0;
    initial begin
        bclk_o = 1'b0;
        fsync_o = 1'b0;
        rxd_o = 1'b0;
    end
    task automatic tick(input logic f, input logic d);
        fsync_o = f;
        rxd_o = d;
        #80;
        txcap = {txcap[30:0], txd_i};
        bclk_o = 1'b1;
        #80;
        bclk_o = 1'b0;
    endtask : tick
    // lsb first, no sync delay; clock stands still between frames except for the gap idle ticks sent before the sync
    task automatic frame(input logic [31:0] w, input int n, input int early, input int gap);
        #3;
        for (int i = 0; i < gap; i++) tick(1'b0, ~rxd_o);
        for (int i = 0; i < n; i++) tick(i == 0 || i == early, w[i]);
        rxd_o = ~rxd_o;
        #80;
        txcap = {txcap[30:0], txd_i};
    endtask : frame
endmodule : apf_codec
`default_nettype wire

/* File: testbench/apf_top_tb.sv */
// apf_top_tb: bench of the audio port block
`timescale 1ns/1ps
`default_nettype none
module apf_top_tb;
    import apf_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, req = 1'b0, wb_we_i = 1'b0, hclk = 1'b0, mute_input_pin_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, rd, w;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, bclk_i, fsync_i, rx_data_i, tx_data_o;
    wire logic mute_output_pin_o, tx_dma_req_o, rx_dma_req_o, err_irq_o;
    int bad_count = 0, checks_done = 0, rx_cnt = 0, nrx = 0;
    apf_rxfmt_t cfg;
    always #10 clk_i = ~clk_i;
    always #20 hclk = ~hclk;
    always @(posedge clk_i) if (rx_dma_req_o === 1'b1) rx_cnt <= rx_cnt + 1;
    apf_codec i_codec (.bclk_o(bclk_i), .fsync_o(fsync_i), .rxd_o(rx_data_i), .txd_i(tx_data_o));
    apf_top i_dut (.clk_i, .rst_i, .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .bclk_i, .fsync_i, .rx_data_i, .tx_data_o,
        .tx_high_rate_clock_i(hclk), .rx_high_rate_clock_i(hclk), .mute_input_pin_i,
        .mute_output_pin_o, .tx_dma_req_o, .rx_dma_req_o, .err_irq_o);
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        req <= 1'b1;
        wb_we_i <= wr;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(negedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        @(posedge clk_i);
        req <= 1'b0;
    endtask : wb
    task automatic send(input logic [31:0] d, input int n, input int e, input int g);
        i_codec.frame(d, n, e, g);
        nrx++;
        while (rx_cnt < nrx) @(posedge clk_i);
    endtask : send
    function automatic logic [31:0] rr(input logic [31:0] x, input logic rv, input int r);
        logic [31:0] y;
        for (int i = 0; i < 32; i++) y[i] = rv ? x[31 - i] : x[i];
        return (y >> r) | (y << (32 - r));
    endfunction : rr
    // mask keeps received bits and the pad source
    task automatic rxchk(input int n, input logic rv, input int r, input logic [1:0] pm, input logic [31:0] mr);
        logic [31:0] vm, m, x, pad;
        int p;
        vm = rr(32'hFFFF_FFFF << (32 - n), rv, r);
        for (int i = 0; i < 32; i++) if (vm[i]) p = i;
        m = (mr & vm) | (32'h1 << p);
        cfg = '{5'(p), pm, 2'h0, 3'((n - 8) / 4), rv, 3'(r / 4)};
        w = $urandom & ~(32'hFFFF_FFFF << n);
        wb(1'b1, ADDR_RXFMT, 32'(cfg));
        wb(1'b1, ADDR_RXMASK, m);
        send(w, n, 0, 0);
        x = rr(w << (32 - n), rv, r);
        pad = pm == PAD_ONE ? 32'hFFFF_FFFF : pm == PAD_BIT ? {32{x[p]}} : 32'h0;
        wb(1'b0, ADDR_RXDATA, 32'h0);
        cmp(rd, (x & m) | (pad & ~m));
    endtask : rxchk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        cmp(rd & m, e);
    endtask : rdchk
    initial begin
        void'($urandom(32'h8bb9));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        cmp(mute_output_pin_o, 1);
        wb(1'b1, ADDR_CTRL, 32'h1);
        for (int k = 0; k < 7; k++) rxchk(8 + 4 * k, 1'(k % 2), 4 * ($urandom % 8), 2'(k % 3), $urandom);
        rxchk(24, 1'b1, 0, PAD_ZERO, 32'hFFFF_FFFF);
        rxchk(32, 1'b0, 0, PAD_ZERO, 32'hFFFF_FFFF);
        $display("test 1 done");
        wb(1'b1, ADDR_MUTE, 32'h1);
        wb(1'b1, ADDR_INTEN, 32'h1);
        wb(1'b1, ADDR_STATUS, 32'h7F);
        send(32'h1111_1111, 32, 0, 0);
        send(32'h2222_2222, 32, 0, 0);
        rdchk(ADDR_STATUS, 32'h1, 32'h1);
        cmp(mute_output_pin_o, 0);
        cmp(err_irq_o, 1);
        rdchk(ADDR_RXDATA, 32'hFFFF_FFFF, 32'h2222_2222);
        send(32'h3333_3333, 32, 0, 0);
        rdchk(ADDR_RXDATA, 32'hFFFF_FFFF, 32'h3333_3333);
        rdchk(ADDR_STATUS, 32'h1, 32'h1);
        wb(1'b1, ADDR_STATUS, 32'h1);
        rdchk(ADDR_STATUS, 32'h1, 32'h0);
        cmp({mute_output_pin_o, err_irq_o}, 2'b10);
        $display("test 2 done");
        wb(1'b1, ADDR_STATUS, 32'h7F);
        send(32'h4444_4444, 32, 5, 0);
        rdchk(ADDR_STATUS, 32'h12, 32'h12);
        rdchk(ADDR_RXDATA, 32'hFFFF_FFFF, 32'h4444_4444);
        wb(1'b1, ADDR_STATUS, 32'h7F);
        send(32'h5555_5555, 32, 0, 1);
        rdchk(ADDR_STATUS, 32'h2, 32'h2);
        rdchk(ADDR_RXDATA, 32'hFFFF_FFFF, 32'h5555_5555);
        $display("test 3 done");
        wb(1'b1, ADDR_STATUS, 32'h7F);
        wb(1'b1, ADDR_TXDATA, 32'h9ABC_DEF0);
        send(32'h0, 32, 0, 0);
        cmp(i_codec.txcap, 32'h9ABC_DEF0);
        rdchk(ADDR_STATUS, 32'h8, 32'h0);
        wb(1'b1, ADDR_TXDATA, 32'h1);
        wb(1'b1, ADDR_TXDATA, 32'h2);
        rdchk(ADDR_STATUS, 32'h20, 32'h20);
        send(32'h0, 32, 0, 0);
        cmp(i_codec.txcap, 32'h1);
        send(32'h0, 32, 0, 0);
        rdchk(ADDR_STATUS, 32'h8, 32'h8);
        $display("test 4 done");
        wb(1'b0, ADDR_CLKCHK_TX, 32'h0);
        cmp(32'(rd[23:16] > 8'h3E && rd[23:16] < 8'h42), 1);
        wb(1'b1, ADDR_CLKCHK_TX, 32'hFF50);
        wb(1'b1, ADDR_STATUS, 32'h7F);
        repeat (200) @(posedge clk_i);
        rdchk(ADDR_STATUS, 32'h44, 32'h40);
        $display("test 5 done");
        wb(1'b1, ADDR_MUTE, 32'h80);
        mute_input_pin_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        cmp(mute_output_pin_o, 0);
        $display("test 6 done");
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        end_sim;
    end
endmodule : apf_top_tb
`default_nettype wire
